// ### rtl/scan_pkg.sv
// Constants and types shared by the boundary-scan data register logic
package scan_pkg;

  localparam int IR_W = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_SAMPLE = 3'h1;
  localparam logic [2:0] IR_PROBE = 3'h3;
  localparam logic [2:0] IR_USER = 3'h4;
  localparam logic [2:0] IR_HIGHZ = 3'h5;
  localparam logic [2:0] IR_CLAMP = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;

  // Position of each cell inside one I/O group of the chain
  localparam int CELLS_PER_IO = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  localparam int PROBE_W = 2;
  localparam int NUM_IO = 4;
  localparam int USER_W = 8;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    SEL_BYP, SEL_BND, SEL_PRB, SEL_USR
  } dr_sel_e;

endpackage

// ### rtl/scan_cell.sv
// One boundary-scan cell: shift stage and latch stage
`timescale 1ns/1ns
`default_nettype none
module scan_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strobes, one clk wide
  input wire logic cap_en,
  input wire logic shift_en,
  input wire logic upd_en,
  // Serial and parallel data
  input wire logic si,
  input wire logic pi,
  output logic so,
  output logic po
);

  logic sh_q;
  logic lat_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 1'b0;
    end else if (cap_en) begin
      sh_q <= pi;
    end else if (shift_en) begin
      sh_q <= si;
    end
  end

  // Latch holds across instruction changes so preloads survive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= 1'b0;
    end else if (upd_en) begin
      lat_q <= sh_q;
    end
  end

  assign so = sh_q;
  assign po = lat_q;

endmodule
`default_nettype wire

// ### rtl/scan_dr.sv
// Test port data registers, instruction decode and pin multiplexing
`timescale 1ns/1ns
`default_nettype none
module scan_dr
  import scan_pkg::*;
#(
  parameter int N_IO = NUM_IO,
  parameter int U_W = USER_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // System logic side
  input wire logic [N_IO-1:0] sys_out,
  input wire logic [N_IO-1:0] sys_oe,
  output logic [N_IO-1:0] core_in,
  // Pad side
  input wire logic [N_IO-1:0] pad_in,
  output logic [N_IO-1:0] pad_out,
  output logic [N_IO-1:0] pad_oe,
  // Probe circuitry
  input wire logic [PROBE_W-1:0] probe_result,
  output logic [PROBE_W-1:0] probe_addr,
  // User data register
  input wire logic [U_W-1:0] user_capture,
  output logic [U_W-1:0] user_data
);

  localparam int NC = CELLS_PER_IO * N_IO;

  function automatic dr_sel_e sel_of(input logic [2:0] code);
    case (code)
      IR_EXTEST, IR_SAMPLE: sel_of = SEL_BND;
      IR_PROBE: sel_of = SEL_PRB;
      IR_USER: sel_of = SEL_USR;
      default: sel_of = SEL_BYP;
    endcase
  endfunction

  function automatic tap_state_e tap_next(input tap_state_e s,
                                          input logic m);
    case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default: tap_next = ST_RESET;
    endcase
  endfunction

  // Pin synchronisers; only the second stage and later are read
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  logic [N_IO-1:0] pad_s1_q;
  logic [N_IO-1:0] pad_s2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h3;
    end else begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;
  assign tms_s = tms_q[1];
  assign tdi_s = tdi_q[1];
  // Edges come from stages two and three, never stage one
  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];

  tap_state_e st_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else if (tck_rise) begin
      st_q <= tap_next(st_q, tms_s);
    end
  end

  // Instruction register
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise && st_q == ST_CAP_IR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise && st_q == ST_SHIFT_IR) begin
      ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_q <= IR_BYPASS;
    end else if (st_q == ST_RESET) begin
      ir_q <= IR_BYPASS;
    end else if (tck_fall && st_q == ST_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  dr_sel_e sel;
  logic bnd_sel;
  logic dr_cap;
  logic dr_shift;
  logic dr_upd;
  assign sel = sel_of(ir_q);
  assign bnd_sel = (sel == SEL_BND);
  assign dr_cap = tck_rise && st_q == ST_CAP_DR;
  assign dr_shift = tck_rise && st_q == ST_SHIFT_DR;
  assign dr_upd = tck_fall && st_q == ST_UPD_DR;

  // Bypass bit
  logic byp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_q <= 1'b0;
    end else if (sel == SEL_BYP) begin
      if (dr_cap) begin
        byp_q <= BYPASS_CAPTURE;
      end else if (dr_shift) begin
        byp_q <= tdi_s;
      end
    end
  end

  // Probe address/result register
  logic [PROBE_W-1:0] prb_sh_q;
  logic [PROBE_W-1:0] prb_addr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prb_sh_q <= '0;
    end else if (sel == SEL_PRB) begin
      if (dr_cap) begin
        prb_sh_q <= probe_result;
      end else if (dr_shift) begin
        prb_sh_q <= {tdi_s, prb_sh_q[PROBE_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prb_addr_q <= '0;
    end else if (sel == SEL_PRB && dr_upd) begin
      prb_addr_q <= prb_sh_q;
    end
  end

  // User data register
  logic [U_W-1:0] usr_sh_q;
  logic [U_W-1:0] usr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usr_sh_q <= '0;
    end else if (sel == SEL_USR) begin
      if (dr_cap) begin
        usr_sh_q <= user_capture;
      end else if (dr_shift) begin
        usr_sh_q <= {tdi_s, usr_sh_q[U_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usr_q <= '0;
    end else if (sel == SEL_USR && dr_upd) begin
      usr_q <= usr_sh_q;
    end
  end

  // Boundary chain: cell 0 nearest TDI, last cell feeds TDO
  logic [NC-1:0] bs_sh;
  logic [NC-1:0] bs_lat;
  logic [NC-1:0] bs_pi;

  for (genvar i = 0; i < N_IO; i++) begin : g_io
    assign bs_pi[CELLS_PER_IO*i+CELL_IN] = pad_s2_q[i];
    assign bs_pi[CELLS_PER_IO*i+CELL_OUT] = sys_out[i];
    assign bs_pi[CELLS_PER_IO*i+CELL_OE] = sys_oe[i];
  end

  for (genvar k = 0; k < NC; k++) begin : g_cell
    scan_cell u_cell (
      .clk(clk),
      .rst_n(rst_n),
      .cap_en(dr_cap && bnd_sel),
      .shift_en(dr_shift && bnd_sel),
      .upd_en(dr_upd && bnd_sel),
      .si((k == 0) ? tdi_s : bs_sh[(k == 0) ? 0 : k-1]),
      .pi(bs_pi[k]),
      .so(bs_sh[k]),
      .po(bs_lat[k])
    );
  end

  // Pin multiplexing
  logic drive_lat;
  logic highz;
  assign drive_lat = (ir_q == IR_EXTEST) || (ir_q == IR_CLAMP);
  assign highz = (ir_q == IR_HIGHZ);

  always_comb begin
    for (int i = 0; i < N_IO; i++) begin
      if (drive_lat) begin
        pad_out[i] = bs_lat[CELLS_PER_IO*i+CELL_OUT];
        pad_oe[i] = bs_lat[CELLS_PER_IO*i+CELL_OE];
      end else begin
        pad_out[i] = sys_out[i];
        pad_oe[i] = sys_oe[i] && !highz;
      end
      if (ir_q == IR_EXTEST) begin
        core_in[i] = bs_lat[CELLS_PER_IO*i+CELL_IN];
      end else begin
        core_in[i] = pad_s2_q[i];
      end
    end
  end

  // Serial output, retimed on the falling test-clock edge
  logic dr_lsb;
  logic tdo_q;
  logic tdo_oe_q;
  logic scanning;

  always_comb begin
    case (sel)
      SEL_BND: dr_lsb = bs_sh[NC-1];
      SEL_PRB: dr_lsb = prb_sh_q[0];
      SEL_USR: dr_lsb = usr_sh_q[0];
      default: dr_lsb = byp_q;
    endcase
  end

  assign scanning = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= (st_q == ST_SHIFT_IR) ? ir_sh_q[0] : dr_lsb;
      tdo_oe_q <= scanning;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign probe_addr = prb_addr_q;
  assign user_data = usr_q;

  // Checks
  sequence byp_cap_s;
    tck_rise && st_q == ST_CAP_DR && sel == SEL_BYP;
  endsequence

  sequence bnd_upd_s;
    tck_fall && st_q == ST_UPD_DR && bnd_sel;
  endsequence

  AST_BYP_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    byp_cap_s |=> !byp_q)
    else $error("bypass bit not cleared on capture");

  AST_BYP_SHIFT: assert property (
    @(posedge clk) disable iff (!rst_n)
    dr_shift && sel == SEL_BYP |=> byp_q == $past(tdi_s))
    else $error("bypass bit did not take serial input");

  AST_BYP_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q != ST_SHIFT_DR && st_q != ST_CAP_DR |=> $stable(byp_q))
    else $error("bypass bit moved outside shift");

  AST_IR_RESET: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q == ST_RESET |=> ir_q == IR_BYPASS)
    else $error("instruction not forced to bypass in reset");

  AST_SEL_BYP: assert property (
    @(posedge clk) disable iff (!rst_n)
    ir_q == IR_HIGHZ || ir_q == IR_CLAMP || ir_q == 3'h2
    |-> sel == SEL_BYP)
    else $error("bypass not selected");

  AST_HIGHZ: assert property (
    @(posedge clk) disable iff (!rst_n)
    ir_q == IR_HIGHZ |-> pad_oe == '0)
    else $error("output driven under high-impedance code");

  AST_CLAMP: assert property (
    @(posedge clk) disable iff (!rst_n)
    ir_q == IR_CLAMP |-> pad_out[0] == bs_lat[CELL_OUT]
    && pad_oe[0] == bs_lat[CELL_OE])
    else $error("clamp does not drive latched values");

  AST_BND_UPDATE: assert property (
    @(posedge clk) disable iff (!rst_n)
    bnd_upd_s |=> bs_lat == $past(bs_sh))
    else $error("latch stage missed update");

  AST_BND_CAPTURE: assert property (
    @(posedge clk) disable iff (!rst_n)
    dr_cap && bnd_sel |=> bs_sh[CELL_IN] == $past(pad_s2_q[0]))
    else $error("input cell missed capture");

  AST_SAMPLE_PASS: assert property (
    @(posedge clk) disable iff (!rst_n)
    ir_q == IR_SAMPLE |-> pad_out == sys_out && pad_oe == sys_oe)
    else $error("sample does not pass system values");

  AST_TDO_EDGE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !tck_fall |=> $stable(tdo) && $stable(tdo_oe))
    else $error("serial output moved off the falling edge");

  AST_TDO_OFF: assert property (
    @(posedge clk) disable iff (!rst_n)
    tck_fall && !scanning |=> !tdo_oe ##1 !tdo_oe)
    else $error("serial output driven while not scanning");

endmodule
`default_nettype wire

// ### tb/tap_host.sv
// Boundary-scan controller model driving the test access pins
`timescale 1ns/1ns
`default_nettype none
module tap_host (
  // Clock used to pace the pins
  input wire logic clk,
  // Test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Test clock stands low between frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One test clock of 800 ns; tdo read one clk after the rise, well
  // after the device moved it on the fall before
  task automatic bit_io(input logic m, input logic d, output logic q);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge clk);
    tck = 1'h1;
    @(negedge clk);
    q = tdo;
    repeat (3) @(negedge clk);
    tck = 1'h0;
  endtask

  task automatic tlr();
    logic q;
    repeat (5) bit_io(1'h1, 1'h1, q);
    bit_io(1'h0, 1'h1, q);
  endtask

  // Idle to idle scan, LSB first; ir selects the instruction path
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    bit_io(1'h1, 1'h0, q);
    if (ir) begin
      bit_io(1'h1, 1'h0, q);
    end
    bit_io(1'h0, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1'h1, 1'h0, q);
    bit_io(1'h0, 1'h0, q);
  endtask
endmodule
`default_nettype wire

// ### tb/boundary_scan_data_registers_test.sv
// Self-checking bench for the boundary-scan data registers
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_data_registers_test
  import scan_pkg::*;
;
  typedef struct {
    logic [2:0] code;
    int len;
    logic hz;
    logic thru;
  } row_s;
  localparam logic [15:0] PAT = 16'hB38D;
  row_s rows[8] = '{'{IR_EXTEST, 12, 1'h0, 1'h0},
    '{IR_SAMPLE, 12, 1'h0, 1'h1}, '{3'h2, 1, 1'h0, 1'h1},
    '{IR_PROBE, 2, 1'h0, 1'h1}, '{IR_USER, 8, 1'h0, 1'h1},
    '{IR_HIGHZ, 1, 1'h1, 1'h0}, '{IR_CLAMP, 1, 1'h0, 1'h0},
    '{IR_BYPASS, 1, 1'h0, 1'h1}};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [3:0] sys_out = 4'h0;
  logic [3:0] sys_oe = 4'h6;
  logic [3:0] pad_in = 4'h3;
  logic [3:0] core_in, pad_out, pad_oe;
  logic [1:0] probe_result = 2'h2;
  logic [1:0] probe_addr;
  logic [7:0] user_capture = 8'hC5;
  logic [7:0] user_data;
  logic [15:0] d, e;
  int mismatches = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  scan_dr i_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sys_out(sys_out),
    .sys_oe(sys_oe), .core_in(core_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .probe_result(probe_result),
    .probe_addr(probe_addr), .user_capture(user_capture),
    .user_data(user_data));

  // A released serial output reads inverted, so a missing drive shows up
  tap_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo_oe ? tdo : ~tdo));

  // Chain image: bit k of a scan is cell 11-k; cell 3i input, 3i+1 data
  function automatic logic [15:0] bnd(input logic [3:0] a, b, c);
    bnd = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      case (i % 3)
        0: bnd[11 - i] = a[i / 3];
        1: bnd[11 - i] = b[i / 3];
        default: bnd[11 - i] = c[i / 3];
      endcase
    end
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is near 2800 clk; seven times that is a hang
  initial begin
    #2000000;
    mismatches++;
    results();
  end

  initial begin
    repeat (8) @(negedge clk);
    check("oe_reset", tdo_oe, 16'h0000);
    check("pads_reset", pad_out, sys_out);
    rst_n = 1'h1;
    host.tlr();
    foreach (rows[r]) begin
      sys_out = 4'(r + 3);
      host.scan(1'h1, 3, 16'(rows[r].code), d);
      host.scan(1'h0, 16, PAT, d);
      case (rows[r].code)
        IR_EXTEST, IR_SAMPLE: e = bnd(pad_in, sys_out, sys_oe);
        IR_PROBE: e = 16'(probe_result);
        IR_USER: e = 16'(user_capture);
        default: e = 16'h0000;
      endcase
      check("dr_capture", d & ~(16'hFFFF << rows[r].len), e);
      e = PAT & (16'hFFFF >> rows[r].len);
      check("dr_path", d >> rows[r].len, e);
      check("oe_idle", tdo_oe, 16'h0000);
      if (rows[r].hz) begin
        check("pad_oe_hz", pad_oe, 16'h0000);
      end
      if (rows[r].thru) begin
        check("pad_out_thru", pad_out, sys_out);
        check("pad_oe_thru", pad_oe, sys_oe);
      end
      if (rows[r].code === IR_PROBE) begin
        check("probe_addr", probe_addr, PAT[15:14]);
      end
      if (rows[r].code === IR_USER) begin
        check("user_data", user_data, PAT[15:8]);
      end
    end
    // Preload first so the pins come up known under EXTEST and CLAMP
    host.scan(1'h1, 3, 16'(IR_SAMPLE), d);
    host.scan(1'h0, 12, bnd(4'h5, 4'h9, 4'hC), d);
    check("sample_cap", d, bnd(pad_in, sys_out, sys_oe));
    check("pads_sample", pad_out, sys_out);
    host.scan(1'h1, 3, 16'(IR_EXTEST), d);
    check("preload_out", pad_out, 16'h0009);
    check("preload_oe", pad_oe, 16'h000C);
    check("preload_in", core_in, 16'h0005);
    host.scan(1'h0, 12, bnd(4'hA, 4'h3, 4'hE), d);
    check("extest_cap", d, bnd(pad_in, sys_out, sys_oe));
    check("extest_out", pad_out, 16'h0003);
    check("extest_oe", pad_oe, 16'h000E);
    check("extest_in", core_in, 16'h000A);
    host.scan(1'h1, 3, 16'(IR_CLAMP), d);
    check("clamp_out", pad_out, 16'h0003);
    check("clamp_oe", pad_oe, 16'h000E);
    host.scan(1'h0, 4, PAT, d);
    check("clamp_path", d, (PAT << 1) & 16'h000F);
    check("clamp_hold", pad_out, 16'h0003);
    host.scan(1'h1, 3, 16'(IR_USER), d);
    host.tlr();
    host.scan(1'h0, 4, PAT, d);
    check("tlr_path", d, (PAT << 1) & 16'h000F);
    host.scan(1'h1, 3, 16'(IR_EXTEST), d);
    @(negedge clk);
    rst_n = 1'h0;
    @(negedge clk);
    check("rst_out", pad_out, sys_out);
    check("rst_oe", pad_oe, sys_oe);
    results();
  end
endmodule
`default_nettype wire
